// ==== ccrs_bank_if.sv ====
// carrier between the register set and its working bank store
`timescale 1ns/1ps
interface ccrs_bank_if;
  logic [1:0] bankSel;
  logic [2:0] regIdx;
  logic [7:0] rdData;
  logic wrEn;
  logic [7:0] wrData;
  logic [7:0] ptrR0;
  logic [7:0] ptrR1;
  modport core (output bankSel, output regIdx, output wrEn, output wrData,
                input rdData, input ptrR0, input ptrR1);
  modport store (input bankSel, input regIdx, input wrEn, input wrData,
                 output rdData, output ptrR0, output ptrR1);
endinterface

// ==== ccrs_bank_store.sv ====
// four banks of eight working registers
`timescale 1ns/1ps
module ccrs_bank_store
  import ccrs_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int REGS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstSync_n,
  // bank access
  ccrs_bank_if.store bankBus
);
  import ccrs_pkg::*;
  // ==========================================
  // storage, flat index = bank*8 + reg, matching 0x00..0x1f
  logic [7:0] bankMem_ff [BANKS*REGS];
  wire [4:0] flatIdx = {bankBus.bankSel, bankBus.regIdx};
  wire [4:0] idxR0 = {bankBus.bankSel, 3'h0};
  wire [4:0] idxR1 = {bankBus.bankSel, 3'h1};

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      for (int i = 0; i < BANKS*REGS; i++) bankMem_ff[i] <= 8'h00;
    end else if (bankBus.wrEn) begin
      bankMem_ff[flatIdx] <= bankBus.wrData;
    end
  end

  assign bankBus.rdData = bankMem_ff[flatIdx];
  assign bankBus.ptrR0 = bankMem_ff[idxR0];
  assign bankBus.ptrR1 = bankMem_ff[idxR1];

  property p_bank_write;
    @(posedge clk_sys) disable iff (!rstSync_n)
      bankBus.wrEn |=> bankMem_ff[$past(flatIdx)] == $past(bankBus.wrData);
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("bank write not stored");
endmodule

// ==== ccrs_core.sv ====
// core register set: banks, status word, accumulator, operand, stack, page
`timescale 1ns/1ps
module ccrs_core
  import ccrs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // byte access to special-function space
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  output logic sfrHit,
  output logic ramSel,
  // bit access by bit address
  input wire logic bitWr,
  input wire logic bitRd,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrData,
  output logic bitRdData,
  output logic bitHit,
  // working register access in active bank
  input wire logic wregWr,
  input wire logic [2:0] wregIdx,
  input wire logic [7:0] wregWrData,
  output logic [7:0] wregRdData,
  // arithmetic result update
  input wire logic accLoad,
  input wire logic [7:0] accResult,
  input wire logic operandLoad,
  input wire logic [7:0] operandResult,
  input wire logic flagUpdate,
  input wire logic rotCarryLoad,
  input wire logic carryIn,
  input wire logic nibbleCarryIn,
  input wire logic excessIn,
  input wire logic mulDivOp,
  // stack
  input wire ccrs_pkg::ccrs_stk_e stackOp,
  // external ram indirect address
  input wire logic xramPtrSel,
  output logic [15:0] xramAddr,
  // register views
  output logic [7:0] accOut,
  output logic [7:0] operandOut,
  output logic [7:0] statusOut,
  output logic [7:0] stackPtrOut,
  output logic [1:0] activeBank
);
  import ccrs_pkg::*;

  // ==========================================
  // reset synchroniser
  logic rstMeta_ff;
  logic rstSync_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // ==========================================
  // helper functions
  function automatic logic isBitAddressable(input logic [7:0] a);
    isBitAddressable = a[7] && (a[2:0] == 3'h0);
  endfunction
  function automatic logic oddParity(input logic [7:0] v);
    oddParity = ^v;
  endfunction

  // ==========================================
  // registers
  logic [7:0] acc_ff;
  logic [7:0] operand_ff;
  logic [7:0] psw_ff;
  logic [7:0] sp_ff;
  logic [7:0] page_ff;
  logic [7:0] nxt_acc;
  logic [7:0] nxt_operand;
  logic [7:0] nxt_psw;
  logic [7:0] nxt_sp;
  logic [7:0] nxt_page;

  // ==========================================
  // address decode
  wire isSfr = sfrAddr[7];
  wire hitAcc = isSfr && (sfrAddr == WORKING_RESULT_REGISTER_ADDR);
  wire hitOp = isSfr && (sfrAddr == MULTIPLY_DIVIDE_OPERAND_ADDR);
  wire hitPsw = isSfr && (sfrAddr == PROGRAM_STATUS_WORD_ADDR);
  wire hitSp = isSfr && (sfrAddr == STACK_POINTER_ADDR);
  wire hitPage = isSfr && (sfrAddr == MEMORY_PAGE_SELECT_ADDR);
  wire anyHit = hitAcc | hitOp | hitPsw | hitSp | hitPage;
  // other sfrs of the 119 live in peripherals; here they read zero
  wire [7:0] byteRead = hitAcc ? acc_ff :
                        hitOp ? operand_ff :
                        hitPsw ? psw_ff :
                        hitSp ? sp_ff :
                        hitPage ? page_ff : 8'h00;

  // bit address: 0x80.. maps to byte {addr[7:3],000}, bit addr[2:0]
  wire [7:0] bitByte = {bitAddr[7:3], 3'h0};
  wire bitIsSfr = bitAddr[7] && isBitAddressable(bitByte);
  wire bAcc = bitIsSfr && (bitByte == WORKING_RESULT_REGISTER_ADDR);
  wire bOp = bitIsSfr && (bitByte == MULTIPLY_DIVIDE_OPERAND_ADDR);
  wire bPsw = bitIsSfr && (bitByte == PROGRAM_STATUS_WORD_ADDR);
  wire bAny = bAcc | bOp | bPsw;
  wire [7:0] bitSrc = bAcc ? acc_ff : bOp ? operand_ff : bPsw ? psw_ff : 8'h00;
  wire [7:0] bitMask = 8'h01 << bitAddr[2:0];

  // ==========================================
  // next-state logic
  always_comb begin
    nxt_acc = acc_ff;
    nxt_operand = operand_ff;
    nxt_psw = psw_ff;
    nxt_sp = sp_ff;
    nxt_page = page_ff;
    // software byte writes; unmapped writes fall through untouched
    if (sfrWr && hitAcc) nxt_acc = sfrWrData;
    if (sfrWr && hitOp) nxt_operand = sfrWrData;
    if (sfrWr && hitPsw) nxt_psw = sfrWrData;
    if (sfrWr && hitSp) nxt_sp = sfrWrData;
    if (sfrWr && hitPage) nxt_page = sfrWrData;
    // single-bit writes
    if (bitWr && bAcc) nxt_acc = bitWrData ? (acc_ff | bitMask) : (acc_ff & ~bitMask);
    if (bitWr && bOp) nxt_operand = bitWrData ? (operand_ff | bitMask)
                                              : (operand_ff & ~bitMask);
    if (bitWr && bPsw) nxt_psw = bitWrData ? (psw_ff | bitMask) : (psw_ff & ~bitMask);
    // execution results win over software writes in the same cycle
    if (accLoad) nxt_acc = accResult;
    if (operandLoad) nxt_operand = operandResult;
    if (flagUpdate) begin
      nxt_psw[CARRY_FLAG_POS] = carryIn;
      if (!mulDivOp) nxt_psw[NIBBLE_CARRY_FLAG_POS] = nibbleCarryIn;
      nxt_psw[ARITH_EXCESS_FLAG_POS] = excessIn;
    end
    if (rotCarryLoad) nxt_psw[CARRY_FLAG_POS] = carryIn;
    case (stackOp)
      CCRS_STK_PUSH: nxt_sp = sp_ff + 8'h01;
      CCRS_STK_POP: nxt_sp = sp_ff - 8'h01;
      default: nxt_sp = nxt_sp;
    endcase
    // parity is not storable: always recomputed from the new accumulator
    nxt_psw[PARITY_FLAG_POS] = oddParity(nxt_acc);
  end

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      acc_ff <= WORKING_RESULT_REGISTER_RST;
      operand_ff <= MULTIPLY_DIVIDE_OPERAND_RST;
      psw_ff <= PROGRAM_STATUS_WORD_RST;
      sp_ff <= STACK_POINTER_RST;
      page_ff <= MEMORY_PAGE_SELECT_RST;
    end else begin
      acc_ff <= nxt_acc;
      operand_ff <= nxt_operand;
      psw_ff <= nxt_psw;
      sp_ff <= nxt_sp;
      page_ff <= nxt_page;
    end
  end

  // ==========================================
  // working bank store
  ccrs_bank_if bankBus ();
  wire [1:0] bankBits = {psw_ff[BANK_SELECT_HIGH_POS], psw_ff[BANK_SELECT_LOW_POS]};
  assign bankBus.bankSel = bankBits;
  assign bankBus.regIdx = wregIdx;
  assign bankBus.wrEn = wregWr;
  assign bankBus.wrData = wregWrData;

  ccrs_bank_store #(
    .BANKS(BANK_COUNT),
    .REGS(REGS_PER_BANK)
  ) u_bank (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_ff),
    .bankBus(bankBus)
  );

  // external ram address: page high, pointer low
  wire [7:0] ptrLow = xramPtrSel ? bankBus.ptrR1 : bankBus.ptrR0;
  wire [15:0] nxt_xram = {page_ff, ptrLow};

  // ==========================================
  // registered outputs; reads answer one cycle after the request
  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      sfrRdData <= 8'h00;
      sfrHit <= 1'b0;
      ramSel <= 1'b0;
      bitRdData <= 1'b0;
      bitHit <= 1'b0;
      wregRdData <= 8'h00;
      xramAddr <= 16'h0000;
    end else begin
      sfrRdData <= sfrRd ? byteRead : 8'h00;
      sfrHit <= sfrRd && anyHit;
      ramSel <= (sfrRd || sfrWr) && !isSfr;
      bitRdData <= bitRd && bAny && bitSrc[bitAddr[2:0]];
      bitHit <= bitRd && bAny;
      wregRdData <= bankBus.rdData;
      xramAddr <= nxt_xram;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      accOut <= WORKING_RESULT_REGISTER_RST;
      operandOut <= MULTIPLY_DIVIDE_OPERAND_RST;
      statusOut <= PROGRAM_STATUS_WORD_RST;
      stackPtrOut <= STACK_POINTER_RST;
      activeBank <= 2'h0;
    end else begin
      accOut <= nxt_acc;
      operandOut <= nxt_operand;
      statusOut <= nxt_psw;
      stackPtrOut <= nxt_sp;
      activeBank <= nxt_psw[BANK_SELECT_HIGH_POS:BANK_SELECT_LOW_POS];
    end
  end

  // ==========================================
  // assertions
  property p_parity;
    @(posedge clk_sys) disable iff (!rstSync_ff) psw_ff[PARITY_FLAG_POS] == ^acc_ff;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity bit does not match accumulator");

  property p_push;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (stackOp == CCRS_STK_PUSH) |=> sp_ff == $past(sp_ff) + 8'h01;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not raise stack pointer");

  property p_pop;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (stackOp == CCRS_STK_POP) |=> sp_ff == $past(sp_ff) - 8'h01;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop did not lower stack pointer");

  property p_sp_reset;
    @(posedge clk_sys) $rose(rstSync_ff) |-> sp_ff == STACK_POINTER_RST;
  endproperty
  a_sp_reset: assert property (p_sp_reset)
    else $error("stack pointer reset value wrong");

  property p_psw_reset;
    @(posedge clk_sys) $rose(rstSync_ff) |->
      psw_ff == PROGRAM_STATUS_WORD_RST && page_ff == MEMORY_PAGE_SELECT_RST;
  endproperty
  a_psw_reset: assert property (p_psw_reset)
    else $error("status word or page not cleared on reset");

  property p_carry;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      flagUpdate |=> psw_ff[CARRY_FLAG_POS] == $past(carryIn);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag not updated");

  property p_excess;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      flagUpdate |=> psw_ff[ARITH_EXCESS_FLAG_POS] == $past(excessIn);
  endproperty
  a_excess: assert property (p_excess)
    else $error("excess flag not updated");

  property p_nibble;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (flagUpdate && !mulDivOp) |=> psw_ff[NIBBLE_CARRY_FLAG_POS] == $past(nibbleCarryIn);
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("nibble carry not updated");

  property p_acc_rw;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (sfrWr && sfrAddr == 8'he0 && !accLoad && !bitWr) ##1 (sfrRd && sfrAddr == 8'he0)
        |=> sfrRdData == $past(sfrWrData, 2);
  endproperty
  a_acc_rw: assert property (p_acc_rw)
    else $error("accumulator read-back mismatch");

  property p_unmapped;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (sfrRd && !anyHit) |=> sfrRdData == 8'h00 && !sfrHit;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_xram;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      1'b1 |=> xramAddr[15:8] == $past(page_ff);
  endproperty
  a_xram: assert property (p_xram)
    else $error("page byte not on external address");

  property p_page_write;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (sfrWr && hitPage) |=> page_ff == $past(sfrWrData);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page register write not stored");

  // bit writes may touch the user flags too, so only plain byte writes count
  property p_user_flags;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (sfrWr && hitPsw && !bitWr) |=>
        psw_ff[USER_FLAG_ZERO_POS] == $past(sfrWrData[USER_FLAG_ZERO_POS]) &&
        psw_ff[USER_FLAG_ONE_POS] == $past(sfrWrData[USER_FLAG_ONE_POS]);
  endproperty
  a_user_flags: assert property (p_user_flags)
    else $error("user flag not stored");

  property p_ram_sel;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      ((sfrRd || sfrWr) && !sfrAddr[7]) |=> ramSel;
  endproperty
  a_ram_sel: assert property (p_ram_sel)
    else $error("low direct address did not select ram");

  property p_bit_miss;
    @(posedge clk_sys) disable iff (!rstSync_ff)
      (bitRd && !bAny) |=> !bitHit && !bitRdData;
  endproperty
  a_bit_miss: assert property (p_bit_miss)
    else $error("unmapped bit read not zero");
endmodule

// ==== ccrs_cpu_model.sv ====
// model of the instruction execution logic that updates the core registers
`timescale 1ns/1ps
module ccrs_cpu_model
  import ccrs_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // result updates
  output logic accLoad,
  output logic [7:0] accResult,
  output logic operandLoad,
  output logic [7:0] operandResult,
  output logic flagUpdate,
  output logic rotCarryLoad,
  output logic carryIn,
  output logic nibbleCarryIn,
  output logic excessIn,
  output logic mulDivOp,
  output ccrs_pkg::ccrs_stk_e stackOp
);
  // ==========================================
  // idle state
  initial begin
    {accLoad, operandLoad, flagUpdate, rotCarryLoad, mulDivOp} = 5'h00;
    {accResult, operandResult} = 16'h0000;
    {carryIn, nibbleCarryIn, excessIn} = 3'h0;
    stackOp = CCRS_STK_HOLD;
  end
  // ==========================================
  // one execution step: held for one edge, then data lines inverted
  // so a stale value is never mistaken for a fresh result
  task automatic exec(input logic al, input logic [7:0] a, input logic ol,
                      input logic [7:0] o, input logic fu, input logic rc,
                      input logic [2:0] cne, input logic m, input ccrs_stk_e s);
    @(posedge clk_sys);
    {accLoad, accResult, operandLoad, operandResult} <= {al, a, ol, o};
    {flagUpdate, rotCarryLoad, mulDivOp} <= {fu, rc, m};
    {carryIn, nibbleCarryIn, excessIn} <= cne;
    stackOp <= s;
    @(posedge clk_sys);
    {accLoad, operandLoad, flagUpdate, rotCarryLoad, mulDivOp} <= 5'h00;
    {accResult, operandResult} <= ~{a, o};
    {carryIn, nibbleCarryIn, excessIn} <= ~cne;
    stackOp <= CCRS_STK_HOLD;
    @(negedge clk_sys);
  endtask
endmodule

// ==== ccrs_pkg.sv ====
// package of constants and types for the core register set
package ccrs_pkg;
  // ==========================================
  // widths and geometry
  localparam int DATA_W = 8;
  localparam int BANK_COUNT = 4;
  localparam int REGS_PER_BANK = 8;
  localparam int SFR_TOTAL = 119;
  // ==========================================
  // register offsets
  localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
  localparam logic [7:0] MEMORY_PAGE_SELECT_ADDR = 8'h92;
  localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hd0;
  localparam logic [7:0] WORKING_RESULT_REGISTER_ADDR = 8'he0;
  localparam logic [7:0] MULTIPLY_DIVIDE_OPERAND_ADDR = 8'hf0;
  localparam logic [7:0] SFR_BASE_ADDR = 8'h80;
  // ==========================================
  // reset values
  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [7:0] MEMORY_PAGE_SELECT_RST = 8'h00;
  localparam logic [7:0] PROGRAM_STATUS_WORD_RST = 8'h00;
  localparam logic [7:0] WORKING_RESULT_REGISTER_RST = 8'h00;
  localparam logic [7:0] MULTIPLY_DIVIDE_OPERAND_RST = 8'h00;
  // ==========================================
  // status word field positions
  localparam int CARRY_FLAG_POS = 7;
  localparam int NIBBLE_CARRY_FLAG_POS = 6;
  localparam int USER_FLAG_ZERO_POS = 5;
  localparam int BANK_SELECT_HIGH_POS = 4;
  localparam int BANK_SELECT_LOW_POS = 3;
  localparam int ARITH_EXCESS_FLAG_POS = 2;
  localparam int USER_FLAG_ONE_POS = 1;
  localparam int PARITY_FLAG_POS = 0;
  // ==========================================
  // stack operations
  typedef enum logic [1:0] {
    CCRS_STK_HOLD = 2'b00,
    CCRS_STK_PUSH = 2'b01,
    CCRS_STK_POP = 2'b10
  } ccrs_stk_e;
endpackage

// ==== cpu_core_register_set_tb.sv ====
// self-checking testbench of the core register set
`timescale 1ns/1ps
module cpu_core_register_set_tb;
  import ccrs_pkg::*;
  logic clk_sys, arst_n, sfrWr, sfrRd, bitWr, bitRd, bitWrData, wregWr, xramPtrSel;
  logic [7:0] sfrAddr, sfrWrData, bitAddr, wregWrData, sfrRdData, wregRdData;
  logic [7:0] accOut, operandOut, statusOut, stackPtrOut, accResult, operandResult;
  logic [2:0] wregIdx;
  logic [1:0] activeBank;
  logic [15:0] xramAddr;
  logic sfrHit, ramSel, bitRdData, bitHit, accLoad, operandLoad, flagUpdate;
  logic rotCarryLoad, carryIn, nibbleCarryIn, excessIn, mulDivOp;
  ccrs_stk_e stackOp;
  int mismatches = 0;
  int nCompared = 0;
  ccrs_core DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .sfrHit(sfrHit), .ramSel(ramSel),
    .bitWr(bitWr), .bitRd(bitRd), .bitAddr(bitAddr), .bitWrData(bitWrData),
    .bitRdData(bitRdData), .bitHit(bitHit), .wregWr(wregWr), .wregIdx(wregIdx),
    .wregWrData(wregWrData), .wregRdData(wregRdData), .accLoad(accLoad),
    .accResult(accResult), .operandLoad(operandLoad), .operandResult(operandResult),
    .flagUpdate(flagUpdate), .rotCarryLoad(rotCarryLoad), .carryIn(carryIn),
    .nibbleCarryIn(nibbleCarryIn), .excessIn(excessIn), .mulDivOp(mulDivOp),
    .stackOp(stackOp), .xramPtrSel(xramPtrSel), .xramAddr(xramAddr), .accOut(accOut),
    .operandOut(operandOut), .statusOut(statusOut), .stackPtrOut(stackPtrOut),
    .activeBank(activeBank)
  );
  ccrs_cpu_model cpu (
    .clk_sys(clk_sys), .accLoad(accLoad), .accResult(accResult),
    .operandLoad(operandLoad), .operandResult(operandResult), .flagUpdate(flagUpdate),
    .rotCarryLoad(rotCarryLoad), .carryIn(carryIn), .nibbleCarryIn(nibbleCarryIn),
    .excessIn(excessIn), .mulDivOp(mulDivOp), .stackOp(stackOp)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ==========================================
  // access tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {sfrWr, sfrAddr, sfrWrData} <= {1'b1, a, d};
    @(posedge clk_sys);
    {sfrWr, sfrWrData} <= {1'b0, ~d};
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic hit);
    @(posedge clk_sys);
    {sfrRd, sfrAddr} <= {1'b1, a};
    @(posedge clk_sys);
    sfrRd <= 1'b0;
    @(negedge clk_sys);
    if (a >= 8'h80) chk("sfrRdData", {8'h00, d}, {8'h00, sfrRdData});
    chk("sfrHit", {15'h0, hit}, {15'h0, sfrHit});
    chk("ramSel", {15'h0, a < 8'h80}, {15'h0, ramSel});
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk_sys);
    {bitWr, bitAddr, bitWrData} <= {1'b1, a, v};
    @(posedge clk_sys);
    {bitWr, bitWrData} <= {1'b0, ~v};
  endtask
  task automatic br(input logic [7:0] a, input logic v, input logic hit);
    @(posedge clk_sys);
    {bitRd, bitAddr} <= {1'b1, a};
    @(posedge clk_sys);
    bitRd <= 1'b0;
    @(negedge clk_sys);
    chk("bitRdData", {15'h0, v}, {15'h0, bitRdData});
    chk("bitHit", {15'h0, hit}, {15'h0, bitHit});
  endtask
  task automatic ww(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    {wregWr, wregIdx, wregWrData} <= {1'b1, i, d};
    @(posedge clk_sys);
    {wregWr, wregWrData} <= {1'b0, ~d};
  endtask
  task automatic wrd(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    wregIdx <= i;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("wregRdData", {8'h00, d}, {8'h00, wregRdData});
  endtask
  task automatic complete_run();
    if (mismatches == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end
  // ==========================================
  // tests
  initial begin
    {arst_n, sfrWr, sfrRd, bitWr, bitRd, bitWrData, wregWr, xramPtrSel} = 8'h00;
    {sfrAddr, sfrWrData, bitAddr, wregWrData} = 32'h0000_0000;
    wregIdx = 3'h0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(8'h81, 8'h07, 1'b1);
    rd(8'h92, 8'h00, 1'b1);
    rd(8'hd0, 8'h00, 1'b1);
    rd(8'he0, 8'h00, 1'b1);
    rd(8'hf0, 8'h00, 1'b1);
    wr(8'he0, 8'h5a);
    rd(8'he0, 8'h5a, 1'b1);
    chk("statusOut", 16'h0000, {8'h00, statusOut});
    wr(8'he0, 8'h07);
    chk("statusOut", 16'h0001, {8'h00, statusOut});
    // parity bit is written as 0 here and must still read odd parity
    wr(8'hd0, 8'h26);
    rd(8'hd0, 8'h27, 1'b1);
    wr(8'hf0, 8'ha5);
    rd(8'hf0, 8'ha5, 1'b1);
    wr(8'h92, 8'h12);
    rd(8'h92, 8'h12, 1'b1);
    wr(8'h81, 8'h30);
    rd(8'h81, 8'h30, 1'b1);
    wr(8'h93, 8'hff);
    rd(8'h93, 8'h00, 1'b0);
    rd(8'h80, 8'h00, 1'b0);
    rd(8'h7f, 8'h00, 1'b0);
    bw(8'hd5, 1'b0);
    br(8'hd5, 1'b0, 1'b1);
    bw(8'he7, 1'b1);
    br(8'he7, 1'b1, 1'b1);
    chk("statusOut", 16'h0006, {8'h00, statusOut});
    chk("accOut", 16'h0087, {8'h00, accOut});
    br(8'hf0, 1'b1, 1'b1);
    bw(8'hf1, 1'b1);
    br(8'hf1, 1'b1, 1'b1);
    bw(8'h95, 1'b1);
    br(8'h95, 1'b0, 1'b0);
    rd(8'h92, 8'h12, 1'b1);
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, {3'h0, b[1:0], 3'h0});
      chk("activeBank", {14'h0, b[1:0]}, {14'h0, activeBank});
      ww(3'h0, 8'h40 + b[7:0]);
      ww(3'h1, 8'h50 + b[7:0]);
      ww(3'h7, 8'h70 + b[7:0]);
    end
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, {3'h0, b[1:0], 3'h0});
      wrd(3'h0, 8'h40 + b[7:0]);
      wrd(3'h7, 8'h70 + b[7:0]);
      @(posedge clk_sys);
      xramPtrSel <= b[0];
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("xramAddr", {8'h12, b[0] ? 8'h50 : 8'h40} + b[7:0], xramAddr);
    end
    cpu.exec(1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0, CCRS_STK_PUSH);
    cpu.exec(1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0, CCRS_STK_PUSH);
    chk("stackPtrOut", 16'h0032, {8'h00, stackPtrOut});
    cpu.exec(1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0, CCRS_STK_POP);
    rd(8'h81, 8'h31, 1'b1);
    cpu.exec(1'b1, 8'h03, 1'b0, 8'h00, 1'b1, 1'b0, 3'b110, 1'b0, CCRS_STK_HOLD);
    chk("statusOut", 16'h00d8, {8'h00, statusOut});
    chk("accOut", 16'h0003, {8'h00, accOut});
    // multiply leaves the nibble carry alone
    cpu.exec(1'b0, 8'h00, 1'b1, 8'h9c, 1'b1, 1'b0, 3'b001, 1'b1, CCRS_STK_HOLD);
    chk("statusOut", 16'h005c, {8'h00, statusOut});
    chk("operandOut", 16'h009c, {8'h00, operandOut});
    cpu.exec(1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1, 3'b100, 1'b0, CCRS_STK_HOLD);
    chk("statusOut", 16'h00dc, {8'h00, statusOut});
    cpu.exec(1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 3'b000, 1'b0, CCRS_STK_HOLD);
    rd(8'hd0, 8'h18, 1'b1);
    complete_run();
  end
endmodule
